// ==== design/flash_id_pkg.sv ====
// Function
// - In deep sleep, ignore all instructions except wake-and-identify, which wakes the device.
// - Wake-only: opcode ABh alone, then standby after the wake delay.
// - Identify: ABh, three dummy bytes, then device code MSB first on falling edges.
// - Device code repeats while clocked; chip select rising ends the instruction.
// - Standby immediately if awake; after identify-wake delay if it was asleep.
// - Wake-and-identify returns the device code when awake and not busy.
// - Wake-and-identify during erase, program or status write is not decoded.
// - 90h plus address: 000000h gives maker then device; 000001h device first.
// - 9Fh returns maker code, memory type, then capacity.
// - Standard identify shifts 24 bits on falling edges; chip select high stops it.
// - Standard identify during erase or program is not decoded.
// - 3Ah enters OTP mode; extra sector maps at 03F000h to 03F0FFh.
// - In OTP mode the protect bit position reports the lock flag.
// - In OTP mode program and erase are refused while lock is 1.
// - In OTP mode a status write ignores its data and sets lock.
// - Extra sector writable only with lock 0 and protect field 000.
// - Write-disable 04h leaves OTP mode and restores normal mapping.
// - Delivered state: array reads FFh, status register reads 00h.
// - After power-up, write instructions are inhibited for 1 to 10 ms.
// - Wake-only delay to standby is at most 3 us.
// - Identify wake delay to standby is at most 1.8 us.
package flash_id_pkg;

    // Instruction codes
    localparam logic [7:0] OP_WAKE_ID       = 8'hab;
    localparam logic [7:0] OP_MAKER_DEV     = 8'h90;
    localparam logic [7:0] OP_STD_ID        = 8'h9f;
    localparam logic [7:0] OP_OTP_ENTER     = 8'h3a;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
    localparam logic [7:0] OP_DEEP_SLEEP    = 8'hb9;

    // Identification bytes, values arbitrary
    localparam logic [7:0] MAKER_CODE_DEF   = 8'h5a;
    localparam logic [7:0] DEVICE_CODE_DEF  = 8'h11;
    localparam logic [7:0] MEM_TYPE_DEF     = 8'h31;
    localparam logic [7:0] CAPACITY_DEF     = 8'h12;

    // Frame bit positions, counted in rising clock edges after select
    localparam int         CNT_W            = 6;
    localparam logic [5:0] OPCODE_LAST      = 6'h07;
    localparam logic [5:0] OPCODE_END       = 6'h08;
    localparam logic [5:0] STATUS_WR_END    = 6'h10;
    localparam logic [5:0] ADDR_LAST        = 6'h1f;
    localparam logic [5:0] ADDR_END         = 6'h20;
    localparam logic [5:0] CNT_TOP          = 6'h3f;
    localparam logic [5:0] STD_ID_END       = 6'h18;

    // OTP window and status reset values
    localparam logic [23:0] OTP_BASE        = 24'h03f000;
    localparam logic [23:0] OTP_LAST        = 24'h03f0ff;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam int          PROTECT_POS     = 7;
    localparam logic [2:0]  BP_CLEAR        = 3'h0;

    // Timing
    localparam int CLK_PERIOD_NS            = 5;
    localparam int WAKE_DELAY_NS            = 3000;
    localparam int IDENTIFY_WAKE_DELAY_NS   = 1800;
    localparam int POWERUP_INHIBIT_MIN_MS   = 1;
    localparam int WAKE_CYCLES              = WAKE_DELAY_NS / CLK_PERIOD_NS;
    localparam int ID_WAKE_CYCLES           = IDENTIFY_WAKE_DELAY_NS / CLK_PERIOD_NS;
    localparam int POWERUP_CYCLES           =
        (POWERUP_INHIBIT_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W                  = 18;

    // Power state
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_SLEEP   = 3'b010,
        ST_WAKING  = 3'b100
    } power_state_t;

endpackage : flash_id_pkg

// ==== design/flash_delay_timer.sv ====
`timescale 1ns/100ps
module flash_delay_timer #(
    parameter int         WIDTH       = 18,
    parameter int         RESET_COUNT = 0
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // Load
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_count,
    // Status
    output logic                  o_busy
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    initial begin
        if (WIDTH < 2 || WIDTH > 30 || RESET_COUNT < 0 || RESET_COUNT >= (1 << WIDTH)) begin
            $error("flash_delay_timer: bad WIDTH or RESET_COUNT");
        end
    end

    // Down counter; a load overrides the running count
    always_comb begin
        next_count = count;
        if (i_load) begin
            next_count = i_count;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count <= WIDTH'(RESET_COUNT);
        end else begin
            count <= next_count;
        end
    end

    assign o_busy = (count != '0);

endmodule : flash_delay_timer

// ==== design/flash_id_ctrl.sv ====
`timescale 1ns/100ps
module flash_id_ctrl
    import flash_id_pkg::*;
#(
    parameter int         PUW_CYCLES  = flash_id_pkg::POWERUP_CYCLES,
    parameter logic [7:0] MAKER_CODE  = flash_id_pkg::MAKER_CODE_DEF,
    parameter logic [7:0] DEVICE_CODE = flash_id_pkg::DEVICE_CODE_DEF,
    parameter logic [7:0] MEM_TYPE    = flash_id_pkg::MEM_TYPE_DEF,
    parameter logic [7:0] CAPACITY    = flash_id_pkg::CAPACITY_DEF
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Serial link, sampled on i_clk
    input  wire logic        i_cs_n,
    input  wire logic        i_sclk,
    input  wire logic        i_serial_in,
    output logic             o_serial_out,
    output logic             o_serial_out_oe_n,
    // Device state from the rest of the flash
    input  wire logic        i_pe_busy,
    input  wire logic        i_status_write_busy,
    input  wire logic        i_write_enable,
    input  wire logic        i_status_protect,
    input  wire logic [2:0]  i_block_protect,
    input  wire logic [23:0] i_array_addr,
    // Mode and permission outputs
    output logic             o_standby,
    output logic             o_deep_sleep,
    output logic             o_otp_mode,
    output logic             o_otp_lock,
    output logic             o_otp_hit,
    output logic             o_status_protect_view,
    output logic             o_otp_pe_allow,
    output logic             o_other_pe_allow,
    output logic             o_write_inhibit
);
    import flash_id_pkg::*;

    initial begin
        if (PUW_CYCLES < 1 || PUW_CYCLES >= (1 << TIMER_W)) begin
            $error("flash_id_ctrl: PUW_CYCLES out of range");
        end
    end

    // Edge detection on the link pins
    logic sclk_q;
    logic cs_n_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_fall;
    logic busy_any;

    assign sclk_rise = !i_cs_n && i_sclk && !sclk_q;
    assign sclk_fall = !i_cs_n && !i_sclk && sclk_q;
    assign cs_rise   = i_cs_n && !cs_n_q;
    assign cs_fall   = !i_cs_n && cs_n_q;
    assign busy_any  = i_pe_busy || i_status_write_busy;

    // Frame decode state
    logic [CNT_W-1:0] bit_cnt;
    logic [7:0]       shift;
    logic [7:0]       opcode;
    logic             op_valid;
    logic             addr_lsb;
    logic             id_wake;
    logic             id_maker;
    logic             id_std;
    logic [CNT_W-1:0] next_bit_cnt;
    logic [7:0]       next_shift;
    logic [7:0]       next_opcode;
    logic             next_op_valid;
    logic             next_addr_lsb;
    logic             next_id_wake;
    logic             next_id_maker;
    logic             next_id_std;
    logic [7:0]       op_now;

    // Power and OTP state
    power_state_t     state;
    power_state_t     next_state;
    logic             otp_mode;
    logic             otp_lock;
    logic             next_otp_mode;
    logic             next_otp_lock;
    logic             wake_load;
    logic [TIMER_W-1:0] wake_count;
    logic             wake_busy;
    logic             pu_busy;

    // Serial output
    logic             next_so;
    logic             next_so_oe_n;
    logic [CNT_W-1:0] out_idx;
    logic [7:0]       out_byte;

    // Shift in on rising edges; the count wraps 63 to 32 so ABh and 90h id bytes keep cycling
    always_comb begin
        op_now        = {shift[6:0], i_serial_in};
        next_bit_cnt  = bit_cnt;
        next_shift    = shift;
        next_opcode   = opcode;
        next_op_valid = op_valid;
        next_addr_lsb = addr_lsb;
        next_id_wake  = id_wake;
        next_id_maker = id_maker;
        next_id_std   = id_std;
        if (cs_fall) begin
            // A new select always starts with a fresh opcode
            next_bit_cnt  = '0;
            next_op_valid = 1'b0;
            next_id_wake  = 1'b0;
            next_id_maker = 1'b0;
            next_id_std   = 1'b0;
            next_addr_lsb = 1'b0;
        end else if (sclk_rise) begin
            next_shift   = op_now;
            next_bit_cnt = (bit_cnt == CNT_TOP) ? ADDR_END : bit_cnt + 1'b1;
            if (bit_cnt == OPCODE_LAST) begin
                next_opcode   = op_now;
                next_op_valid = 1'b1;
                // Sleep lets only the wake code through; busy cycles block ids, except that a status write alone does not block 9Fh
                next_id_wake  = (op_now == OP_WAKE_ID) && !busy_any;
                next_id_maker = (op_now == OP_MAKER_DEV) && !busy_any
                                && (state == ST_STANDBY);
                next_id_std   = (op_now == OP_STD_ID) && !i_pe_busy
                                && (state == ST_STANDBY);
            end
            if (bit_cnt == ADDR_LAST) begin
                next_addr_lsb = i_serial_in;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_q   <= 1'b0;
            cs_n_q   <= 1'b1;
            bit_cnt  <= '0;
            shift    <= 8'h00;
            opcode   <= 8'h00;
            op_valid <= 1'b0;
            addr_lsb <= 1'b0;
            id_wake  <= 1'b0;
            id_maker <= 1'b0;
            id_std   <= 1'b0;
        end else begin
            sclk_q   <= i_sclk;
            cs_n_q   <= i_cs_n;
            bit_cnt  <= next_bit_cnt;
            shift    <= next_shift;
            opcode   <= next_opcode;
            op_valid <= next_op_valid;
            addr_lsb <= next_addr_lsb;
            id_wake  <= next_id_wake;
            id_maker <= next_id_maker;
            id_std   <= next_id_std;
        end
    end

    // Identification byte and bit for the current falling edge
    always_comb begin
        out_idx  = id_std ? bit_cnt - OPCODE_END : bit_cnt - ADDR_END;
        out_byte = 8'hff;
        if (id_wake) begin
            out_byte = DEVICE_CODE;
        end else if (id_maker) begin
            out_byte = (out_idx[3] ^ addr_lsb) ? DEVICE_CODE : MAKER_CODE;
        end else if (id_std && bit_cnt < ADDR_END) begin
            case (out_idx[4:3])
                2'b00:   out_byte = MAKER_CODE;
                2'b01:   out_byte = MEM_TYPE;
                2'b10:   out_byte = CAPACITY;
                default: out_byte = 8'hff;
            endcase
        end
    end

    // Output changes on falling edges; deselect releases the pin at once
    always_comb begin
        next_so      = o_serial_out;
        next_so_oe_n = o_serial_out_oe_n;
        if (i_cs_n) begin
            next_so      = 1'b0;
            next_so_oe_n = 1'b1;
        end else if (sclk_fall) begin
            if ((id_wake || id_maker) && bit_cnt >= ADDR_END) begin
                next_so      = out_byte[3'd7 - out_idx[2:0]];
                next_so_oe_n = 1'b0;
            end else if (id_std && bit_cnt >= OPCODE_END) begin
                next_so      = out_byte[3'd7 - out_idx[2:0]];
                next_so_oe_n = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_serial_out      <= 1'b0;
            o_serial_out_oe_n <= 1'b1;
        end else begin
            o_serial_out      <= next_so;
            o_serial_out_oe_n <= next_so_oe_n;
        end
    end

    // Power state, OTP mode and lock; instructions act on deselect
    always_comb begin
        next_state    = state;
        next_otp_mode = otp_mode;
        next_otp_lock = otp_lock;
        wake_load     = 1'b0;
        wake_count    = '0;
        case (state)
            ST_SLEEP: begin
                // Only the wake code leaves sleep; the delay depends on an id read
                if (cs_rise && op_valid && id_wake) begin
                    next_state = ST_WAKING;
                    wake_load  = 1'b1;
                    if (bit_cnt >= ADDR_END) begin
                        wake_count = TIMER_W'(ID_WAKE_CYCLES - 1);
                    end else begin
                        wake_count = TIMER_W'(WAKE_CYCLES - 1);
                    end
                end
            end
            ST_WAKING: begin
                // Host keeps select high meanwhile, so no frame is decoded here
                if (!wake_busy) begin
                    next_state = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (cs_rise && op_valid && bit_cnt == OPCODE_END) begin
                    if (opcode == OP_DEEP_SLEEP && !busy_any) begin
                        next_state = ST_SLEEP;
                    end else if (opcode == OP_OTP_ENTER && !busy_any) begin
                        next_otp_mode = 1'b1;
                    end else if (opcode == OP_WRITE_DISABLE) begin
                        next_otp_mode = 1'b0;
                    end
                end
                // Data byte is ignored; the lock is one-way until power is lost
                if (cs_rise && op_valid && bit_cnt == STATUS_WR_END
                        && opcode == OP_STATUS_WRITE && otp_mode && i_write_enable
                        && !busy_any && !pu_busy) begin
                    next_otp_lock = 1'b1;
                end
            end
            default: begin
                next_state = ST_STANDBY;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state    <= ST_STANDBY;
            otp_mode <= 1'b0;
            otp_lock <= STATUS_RESET[PROTECT_POS];
        end else begin
            state    <= next_state;
            otp_mode <= next_otp_mode;
            otp_lock <= next_otp_lock;
        end
    end

    // Wake delay timer
    flash_delay_timer #(
        .WIDTH       (TIMER_W),
        .RESET_COUNT (0)
    ) u_wake_timer (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (wake_load),
        .i_count (wake_count),
        .o_busy  (wake_busy)
    );

    // Power-up write inhibit timer, started by reset
    flash_delay_timer #(
        .WIDTH       (TIMER_W),
        .RESET_COUNT (PUW_CYCLES)
    ) u_powerup_timer (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (1'b0),
        .i_count ('0),
        .o_busy  (pu_busy)
    );

    // Registered view of modes and write permissions
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_standby             <= 1'b1;
            o_deep_sleep          <= 1'b0;
            o_otp_mode            <= 1'b0;
            o_otp_lock            <= 1'b0;
            o_otp_hit             <= 1'b0;
            o_status_protect_view <= 1'b0;
            o_otp_pe_allow        <= 1'b0;
            o_other_pe_allow      <= 1'b0;
            o_write_inhibit       <= 1'b1;
        end else begin
            o_standby             <= (state == ST_STANDBY);
            o_deep_sleep          <= (state == ST_SLEEP);
            o_otp_mode            <= otp_mode;
            o_otp_lock            <= otp_lock;
            o_otp_hit             <= otp_mode && i_array_addr >= OTP_BASE
                                     && i_array_addr <= OTP_LAST;
            o_status_protect_view <= otp_mode ? otp_lock : i_status_protect;
            o_otp_pe_allow        <= otp_mode && !otp_lock && !pu_busy
                                     && (state == ST_STANDBY)
                                     && i_block_protect == BP_CLEAR;
            o_other_pe_allow      <= !(otp_mode && otp_lock) && !pu_busy
                                     && (state == ST_STANDBY);
            o_write_inhibit       <= pu_busy;
        end
    end

    // Checks
    sleep_ignore_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state == ST_SLEEP && cs_rise && !id_wake) |=> state == ST_SLEEP)
        else $error("sleep left without wake code");

    wake_enter_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state == ST_SLEEP && cs_rise && op_valid && id_wake) |=> state == ST_WAKING)
        else $error("wake code did not start wake");

    wake_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state == ST_SLEEP && cs_rise && id_wake && bit_cnt < ADDR_END)
        |=> ##[1:600] state == ST_STANDBY)
        else $error("wake delay too long");

    id_wake_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state == ST_SLEEP && cs_rise && id_wake && bit_cnt >= ADDR_END)
        |=> ##[1:360] state == ST_STANDBY)
        else $error("identify wake delay too long");

    id_busy_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (sclk_rise && bit_cnt == OPCODE_LAST && busy_any) |=> !id_wake && !id_maker)
        else $error("id decoded while busy");

    std_busy_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (sclk_rise && bit_cnt == OPCODE_LAST && i_pe_busy) |=> !id_std)
        else $error("standard id decoded while busy");

    release_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_cs_n |=> o_serial_out_oe_n)
        else $error("output not released on deselect");

    code_bit_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (sclk_fall && id_wake && bit_cnt == ADDR_END)
        |=> !o_serial_out_oe_n && o_serial_out == DEVICE_CODE[7])
        else $error("device code not MSB first");

    lock_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(otp_lock) |-> $past(otp_mode) && $past(opcode) == OP_STATUS_WRITE)
        else $error("lock set outside OTP status write");

    lock_block_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (otp_mode && otp_lock) |=> !o_other_pe_allow && !o_otp_pe_allow)
        else $error("program allowed while locked");

    wake_cover: cover property (@(posedge i_clk) disable iff (i_rst)
        state == ST_WAKING ##1 state == ST_STANDBY);
    std_id_cover: cover property (@(posedge i_clk) disable iff (i_rst)
        id_std && sclk_fall && bit_cnt == 6'h17);
    lock_cover: cover property (@(posedge i_clk) disable iff (i_rst) $rose(otp_lock));
    maker_cover: cover property (@(posedge i_clk) disable iff (i_rst)
        id_maker && addr_lsb && sclk_fall && bit_cnt == ADDR_END);

endmodule : flash_id_ctrl

// ==== tb/spi_host_model.sv ====
`timescale 1ns/100ps
// Host side of the serial link; every line moves just after a clock edge
module spi_host_model (
    // Clock
    input  wire logic i_clk,
    // Link
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_mosi,
    input  wire logic i_miso
);
    // Deselected and idle from time zero, clock parked low
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
    end
    // Waits n edges and steps off the edge, so no change races the sampler
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : wt
    // Opens a frame; the serial clock stands still outside frames
    task automatic sel();
        o_cs_n = 1'b0;
        wt(2);
    endtask : sel
    // Closes a frame, then keeps select high for the hold the caller needs
    task automatic desel(input int hold);
        wt(2);
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi; // Released data line must not look like a valid bit
        wt(hold);
    endtask : desel
    // One byte MSB first; each clock level stands two cycles, read bit taken on the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_mosi = tx[i];
            wt(2);
            o_sclk = 1'b1;
            rx[i] = i_miso;
            wt(2);
            o_sclk = 1'b0;
        end
    endtask : xfer
endmodule : spi_host_model

// ==== tb/flash_id_wake_otp_commands_bench.sv ====
`timescale 1ns/100ps
module flash_id_wake_otp_commands_bench;
    import flash_id_pkg::*;
    logic        i_clk, i_rst, i_cs_n, i_sclk, i_serial_in, o_serial_out, o_serial_out_oe_n;
    logic        i_pe_busy, i_status_write_busy, i_write_enable, i_status_protect;
    logic [2:0]  i_block_protect;
    logic [23:0] i_array_addr, rx;
    logic        o_standby, o_deep_sleep, o_otp_mode, o_otp_lock, o_otp_hit;
    logic        o_status_protect_view, o_otp_pe_allow, o_other_pe_allow, o_write_inhibit;
    logic        oe_seen;
    int          fails, check_count, cyc;

    // Short power-up count keeps the run brief
    flash_id_ctrl #(.PUW_CYCLES(20)) uut (.i_clk, .i_rst, .i_cs_n, .i_sclk, .i_serial_in,
        .o_serial_out, .o_serial_out_oe_n, .i_pe_busy, .i_status_write_busy, .i_write_enable,
        .i_status_protect, .i_block_protect, .i_array_addr, .o_standby, .o_deep_sleep,
        .o_otp_mode, .o_otp_lock, .o_otp_hit, .o_status_protect_view, .o_otp_pe_allow,
        .o_other_pe_allow, .o_write_inhibit);
    // Released data line floats high through a pull-up, so a late enable shows up as ones
    spi_host_model host (.i_clk(i_clk), .o_cs_n(i_cs_n), .o_sclk(i_sclk),
        .o_mosi(i_serial_in), .i_miso(o_serial_out_oe_n ? 1'b1 : o_serial_out));

    // 200 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        chk({23'h0, got}, {23'h0, exp});
    endtask : chk1
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    // One frame of n bytes; keeps the last three bytes read and the enable seen last
    task automatic run(input logic [47:0] tx, input int n, input int hold);
        logic [7:0] r;
        host.sel();
        for (int k = 0; k < n; k++) begin
            host.xfer(tx[47-8*k -: 8], r);
            rx = {rx[15:0], r};
        end
        oe_seen = o_serial_out_oe_n;
        host.desel(hold);
    endtask : run
    // Standby must come within lim cycles; waiting longer than the limit is the failure
    task automatic wait_sb(input int lim);
        for (int n = 0; n < lim && o_standby !== 1'b1; n++) host.wt(1);
        chk1(o_standby, 1'b1);
    endtask : wait_sb

    task automatic t_reset();
        chk1(o_standby, 1'b1);
        chk1(o_status_protect_view, 1'b0);
        chk1(o_write_inhibit, 1'b1);
        host.wt(30);
        chk1(o_write_inhibit, 1'b0);
        // Outside OTP mode the protect view follows the normal bit
        i_status_protect = 1'b1;
        host.wt(2);
        chk1(o_status_protect_view, 1'b1);
    endtask : t_reset
    // All three identify forms, read past their first byte
    task automatic t_ids();
        logic [47:0] fr [4];
        logic [23:0] ex [4];
        fr = '{{OP_STD_ID, 40'h0}, {OP_MAKER_DEV, 40'h0}, {OP_MAKER_DEV, 24'h1, 16'h0},
               {OP_WAKE_ID, 40'h0}};
        ex = '{{MAKER_CODE_DEF, MEM_TYPE_DEF, CAPACITY_DEF},
               {8'hff, MAKER_CODE_DEF, DEVICE_CODE_DEF}, {8'hff, DEVICE_CODE_DEF, MAKER_CODE_DEF},
               {8'hff, DEVICE_CODE_DEF, DEVICE_CODE_DEF}};
        for (int i = 0; i < 4; i++) begin
            run(fr[i], (i == 0) ? 4 : 6, 4);
            chk(rx, ex[i]);
            chk1(oe_seen, 1'b0);
            chk1(o_serial_out_oe_n, 1'b1);
        end
    endtask : t_ids
    // Busy cycles hide the reads; a status write alone still lets 9Fh through
    task automatic t_busy();
        i_pe_busy = 1'b1;
        run({OP_WAKE_ID, 40'h0}, 6, 4);
        chk1(oe_seen, 1'b1);
        run({OP_STD_ID, 40'h0}, 4, 4);
        chk1(oe_seen, 1'b1);
        i_pe_busy = 1'b0;
        i_status_write_busy = 1'b1;
        run({OP_WAKE_ID, 40'h0}, 6, 4);
        chk1(oe_seen, 1'b1);
        run({OP_STD_ID, 40'h0}, 4, 4);
        chk1(oe_seen, 1'b0);
        i_status_write_busy = 1'b0;
    endtask : t_busy
    task automatic t_sleep();
        run({OP_DEEP_SLEEP, 40'h0}, 1, 4);
        chk1(o_deep_sleep, 1'b1);
        run({OP_STD_ID, 40'h0}, 4, 4);
        chk1(oe_seen, 1'b1);
        run({OP_WAKE_ID, 40'h0}, 1, 2);
        chk1(o_deep_sleep, 1'b0);
        chk1(o_standby, 1'b0);
        wait_sb(600);
        run({OP_DEEP_SLEEP, 40'h0}, 1, 4);
        run({OP_WAKE_ID, 40'h0}, 6, 2);
        chk(rx, {8'hff, DEVICE_CODE_DEF, DEVICE_CODE_DEF});
        chk1(o_standby, 1'b0);
        wait_sb(360);
    endtask : t_sleep
    task automatic t_otp();
        i_block_protect = 3'h0;
        run({OP_OTP_ENTER, 40'h0}, 1, 4);
        chk1(o_otp_mode, 1'b1);
        i_array_addr = OTP_BASE;
        host.wt(2);
        chk1(o_otp_hit, 1'b1);
        chk1(o_otp_pe_allow, 1'b1);
        i_array_addr = 24'h03f100;
        i_block_protect = 3'h1;
        host.wt(2);
        chk1(o_otp_hit, 1'b0);
        chk1(o_otp_pe_allow, 1'b0);
        chk1(o_other_pe_allow, 1'b1);
        chk1(o_status_protect_view, 1'b0);
        i_block_protect = 3'h0;
        // Without the write enable latch the status write must not lock
        run({OP_STATUS_WRITE, 40'h0}, 2, 4);
        chk1(o_otp_lock, 1'b0);
        i_write_enable = 1'b1;
        run({OP_STATUS_WRITE, 40'h0}, 2, 4);
        chk1(o_otp_lock, 1'b1);
        chk1(o_status_protect_view, 1'b1);
        chk1(o_otp_pe_allow, 1'b0);
        chk1(o_other_pe_allow, 1'b0);
        run({OP_WRITE_DISABLE, 40'h0}, 1, 4);
        i_array_addr = OTP_BASE;
        host.wt(2);
        chk1(o_otp_mode, 1'b0);
        chk1(o_otp_hit, 1'b0);
        chk1(o_other_pe_allow, 1'b1);
        chk1(o_status_protect_view, 1'b1);
        i_write_enable = 1'b0;
        i_status_protect = 1'b0;
        host.wt(2);
        chk1(o_status_protect_view, 1'b0);
    endtask : t_otp

    // Reset for 16 cycles, then the scenarios in turn
    initial begin
        {i_pe_busy, i_status_write_busy, i_write_enable, i_status_protect} = 4'h0;
        i_block_protect = 3'h0;
        i_array_addr = 24'h0;
        i_rst = 1'b1;
        repeat (16) @(posedge i_clk);
        #1 i_rst = 1'b0;
        t_reset();
        t_ids();
        t_busy();
        t_sleep();
        t_otp();
        wrap_up();
    end
endmodule : flash_id_wake_otp_commands_bench
